/* pkg/pin_mux_pkg.sv */
// register map, field positions and encodings for the shared pin mux
// assumes one 100 MHz core clock and an avalon-mm slave port
// How it works
// R01: six compare pins follow action, tri-state on protect
// R02: three simple compare pins, tri-state on protect
// R03: timer 1-3 compare pins, tri-state on protect
// R04: timer direction pin low up, high down
// R05: timer clock pin feeds timers' external clock
// R06: converter start pin triggers the converter
// R07: capture 1-2 to capture or quadrature; 3-4 capture
// R08: software latched external flag output
// R09: branch taken when test input low; board pulls high
// R10: clock out pin drives selected internal clock
// R11: serial pins carry serial function or gpio
// R12: port b/c pins: gpio or peripheral, never both
// R13: maskable protect input, low forces compare high-z
// R14: per pin function select, direction and data bits
package pin_mux_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_PORT_B = 5'h00;
    localparam logic [4:0] ADDR_PORT_C = 5'h04;
    localparam logic [4:0] ADDR_SERIAL = 5'h08;
    localparam logic [4:0] ADDR_ACTION = 5'h0C;
    localparam logic [4:0] ADDR_SYSTEM = 5'h10;
    // ------------------------------------------------------------
    // writable bits and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] MASK_PORT = 32'h00FFFFFF;
    localparam logic [31:0] MASK_SERIAL = 32'h003F3F3F;
    localparam logic [31:0] MASK_ACTION = 32'h3F3F0FFF;
    localparam logic [31:0] MASK_SYSTEM = 32'h0000001F;
    localparam logic [31:0] RST_PORT = 32'h00000000;
    localparam logic [31:0] RST_SERIAL = 32'h00000000;
    localparam logic [31:0] RST_ACTION = 32'h00000000;
    localparam logic [31:0] RST_SYSTEM = 32'h00000010;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FSEL_LSB = 0;
    localparam int DIR_LSB = 8;
    localparam int DATA_LSB = 16;
    localparam int PIN_LSB = 24;
    localparam int CMP_ACT_LSB = 0;
    localparam int SIMPLE_ACT_LSB = 16;
    localparam int TIMER_ACT_LSB = 24;
    localparam int SYS_FLAG_BIT = 0;
    localparam int SYS_CLOCK_OUT_SOURCE_SEL_LSB = 1;
    localparam int SYS_QUAD_BIT = 3;
    localparam int SYS_UNMASK_BIT = 4;
    localparam int SYS_PROT_LVL_BIT = 8;
    localparam int SYS_TRISTATE_BIT = 9;
    localparam int SYS_BRANCH_LVL_BIT = 10;
    // ------------------------------------------------------------
    // pin positions inside port b and port c
    // ------------------------------------------------------------
    localparam int PB_TIMER_LSB = 3;
    localparam int PB_TIMER_DIR = 6;
    localparam int PB_TIMER_CLK = 7;
    localparam int PC_CONV_START = 0;
    localparam int PC_CLOCK_OUT = 1;
    localparam int PC_EXT_FLAG = 2;
    localparam int PC_BRANCH = 3;
    localparam int PC_CAP_LSB = 4;
    localparam int SYNC_W = 23;
    localparam logic [22:0] SYNC_RST = 23'h7FFFFF;
    // ------------------------------------------------------------
    // output action encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_FORCE_LOW = 2'h0,
        ACT_ACTIVE_LOW = 2'h1,
        ACT_ACTIVE_HIGH = 2'h2,
        ACT_FORCE_HIGH = 2'h3
    } action_t;
endpackage

/* hw/shared_pin_function_mux.sv */
// shared pin function mux with compare output protection
// assumes peripheral signals on core_clk; pins arrive asynchronously
`timescale 1ns/10ps
module shared_pin_function_mux (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic [pin_mux_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic POWER_DRIVE_PROTECT_N,
    input wire logic [5:0] CMP_WAVE,
    input wire logic [2:0] SIMPLE_WAVE,
    input wire logic [2:0] TIMER_WAVE,
    input wire logic [3:0] CLK_SRC,
    input wire logic [5:0] SER_PERIPH_OUT,
    input wire logic [5:0] SER_PERIPH_OE_N,
    output logic [5:0] SER_PERIPH_IN,
    output logic TIMER_COUNT_DOWN,
    output logic TIMER_EXT_CLK,
    output logic CONVERTER_START,
    output logic [3:0] EDGE_LATCH,
    output logic [1:0] QUADRATURE,
    output logic BRANCH_ON_TEST_LOW,
    output logic [5:0] CMP_OUT,
    output logic [5:0] CMP_OE_N,
    input wire logic [7:0] PB_IN,
    output logic [7:0] PB_OUT,
    output logic [7:0] PB_OE_N,
    input wire logic [7:0] PC_IN,
    output logic [7:0] PC_OUT,
    output logic [7:0] PC_OE_N,
    input wire logic [5:0] SER_IN,
    output logic [5:0] SER_OUT,
    output logic [5:0] SER_OE_N
);
    import pin_mux_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r & mask;
    endfunction

    function automatic logic act_level(input logic wave, input logic [1:0] act);
        logic v;
        v = 1'b0;
        unique case (action_t'(act))
            ACT_FORCE_LOW: v = 1'b0;
            ACT_ACTIVE_LOW: v = ~wave;
            ACT_ACTIVE_HIGH: v = wave;
            ACT_FORCE_HIGH: v = 1'b1;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
        end else begin
            sync1_r <= {POWER_DRIVE_PROTECT_N, SER_IN, PC_IN, PB_IN};
            sync2_r <= sync1_r;
        end
    end

    logic [7:0] pb_pin;
    logic [7:0] pc_pin;
    logic [5:0] ser_pin;
    logic protect_pin_n;
    assign pb_pin = sync2_r[7:0];
    assign pc_pin = sync2_r[15:8];
    assign ser_pin = sync2_r[21:16];
    assign protect_pin_n = sync2_r[22];

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [31:0] pb_r;
    logic [31:0] pc_r;
    logic [31:0] ser_r;
    logic [31:0] act_r;
    logic [31:0] sys_r;
    logic wr_now;
    assign wr_now = AVS_WRITE && !AVS_WAITREQUEST;

    // [R14]
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            pb_r <= RST_PORT;
            pc_r <= RST_PORT;
            ser_r <= RST_SERIAL;
            act_r <= RST_ACTION;
            sys_r <= RST_SYSTEM;
        end else if (wr_now) begin
            if (AVS_ADDRESS == ADDR_PORT_B) begin
                pb_r <= wr_merge(pb_r, AVS_WRITEDATA, AVS_BYTEENABLE, MASK_PORT);
            end
            if (AVS_ADDRESS == ADDR_PORT_C) begin
                pc_r <= wr_merge(pc_r, AVS_WRITEDATA, AVS_BYTEENABLE, MASK_PORT);
            end
            if (AVS_ADDRESS == ADDR_SERIAL) begin
                ser_r <= wr_merge(ser_r, AVS_WRITEDATA, AVS_BYTEENABLE, MASK_SERIAL);
            end
            if (AVS_ADDRESS == ADDR_ACTION) begin
                act_r <= wr_merge(act_r, AVS_WRITEDATA, AVS_BYTEENABLE, MASK_ACTION);
            end
            if (AVS_ADDRESS == ADDR_SYSTEM) begin
                sys_r <= wr_merge(sys_r, AVS_WRITEDATA, AVS_BYTEENABLE, MASK_SYSTEM);
            end
        end
    end

    logic [7:0] pb_fsel;
    logic [7:0] pb_dir;
    logic [7:0] pb_dat;
    logic [7:0] pc_fsel;
    logic [7:0] pc_dir;
    logic [7:0] pc_dat;
    logic [5:0] ser_fsel;
    logic [5:0] ser_dir;
    logic [5:0] ser_dat;
    logic [1:0] clk_sel;
    logic protect_trip;
    assign pb_fsel = pb_r[FSEL_LSB +: 8];
    assign pb_dir = pb_r[DIR_LSB +: 8];
    assign pb_dat = pb_r[DATA_LSB +: 8];
    assign pc_fsel = pc_r[FSEL_LSB +: 8];
    assign pc_dir = pc_r[DIR_LSB +: 8];
    assign pc_dat = pc_r[DATA_LSB +: 8];
    assign ser_fsel = ser_r[FSEL_LSB +: 6];
    assign ser_dir = ser_r[DIR_LSB +: 6];
    assign ser_dat = ser_r[DATA_LSB +: 6];
    assign clk_sel = sys_r[SYS_CLOCK_OUT_SOURCE_SEL_LSB +: 2];
    // masked input never trips, whatever its level [R13]
    assign protect_trip = sys_r[SYS_UNMASK_BIT] && !protect_pin_n;

    // ------------------------------------------------------------
    // avalon slave: one wait cycle, then the answer
    // ------------------------------------------------------------
    logic [31:0] rd_nxt;

    always_comb begin
        rd_nxt = 32'h00000000;
        unique case (AVS_ADDRESS)
            ADDR_PORT_B: rd_nxt = pb_r | {pb_pin, 24'h000000};
            ADDR_PORT_C: rd_nxt = pc_r | {pc_pin, 24'h000000};
            ADDR_SERIAL: rd_nxt = ser_r | {2'h0, ser_pin, 24'h000000};
            ADDR_ACTION: rd_nxt = act_r;
            ADDR_SYSTEM: begin
                rd_nxt = sys_r;
                rd_nxt[SYS_PROT_LVL_BIT] = protect_pin_n;
                rd_nxt[SYS_TRISTATE_BIT] = protect_trip;
                rd_nxt[SYS_BRANCH_LVL_BIT] = pc_pin[PC_BRANCH];
            end
            default: rd_nxt = 32'h00000000;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h00000000;
        end else begin
            if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
                AVS_WAITREQUEST <= 1'b0;
                AVS_READDATA <= rd_nxt;
            end else begin
                AVS_WAITREQUEST <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    logic [5:0] cmp_out_nxt;
    logic [7:0] pb_out_nxt;
    logic [7:0] pb_oe_n_nxt;
    logic [7:0] pc_out_nxt;
    logic [7:0] pc_oe_n_nxt;
    logic [5:0] ser_out_nxt;
    logic [5:0] ser_oe_n_nxt;

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            cmp_out_nxt[i] = act_level(CMP_WAVE[i], act_r[CMP_ACT_LSB + 2*i +: 2]); // [R01]
        end
        // gpio mode by default; peripheral overrides below [R12]
        pb_out_nxt = pb_dat;
        pb_oe_n_nxt = ~pb_dir;
        pc_out_nxt = pc_dat;
        pc_oe_n_nxt = ~pc_dir;
        for (int i = 0; i < 3; i++) begin
            if (pb_fsel[i]) begin
                pb_out_nxt[i] = act_level(SIMPLE_WAVE[i], act_r[SIMPLE_ACT_LSB + 2*i +: 2]);
                pb_oe_n_nxt[i] = protect_trip; // [R02] [R13]
            end
            if (pb_fsel[PB_TIMER_LSB + i]) begin
                pb_out_nxt[PB_TIMER_LSB + i] =
                    act_level(TIMER_WAVE[i], act_r[TIMER_ACT_LSB + 2*i +: 2]);
                pb_oe_n_nxt[PB_TIMER_LSB + i] = protect_trip; // [R03] [R13]
            end
        end
        // input-only peripheral functions release the pin
        if (pb_fsel[PB_TIMER_DIR]) begin
            pb_oe_n_nxt[PB_TIMER_DIR] = 1'b1;
        end
        if (pb_fsel[PB_TIMER_CLK]) begin
            pb_oe_n_nxt[PB_TIMER_CLK] = 1'b1;
        end
        for (int i = 0; i < 8; i++) begin
            if (pc_fsel[i]) begin
                pc_oe_n_nxt[i] = 1'b1;
            end
        end
        if (pc_fsel[PC_CLOCK_OUT]) begin
            pc_out_nxt[PC_CLOCK_OUT] = CLK_SRC[clk_sel]; // [R10]
            pc_oe_n_nxt[PC_CLOCK_OUT] = 1'b0;
        end
        if (pc_fsel[PC_EXT_FLAG]) begin
            pc_out_nxt[PC_EXT_FLAG] = sys_r[SYS_FLAG_BIT]; // [R08]
            pc_oe_n_nxt[PC_EXT_FLAG] = 1'b0;
        end
        for (int i = 0; i < 6; i++) begin
            // serial block decides its own pin direction [R11]
            ser_out_nxt[i] = ser_fsel[i] ? SER_PERIPH_OUT[i] : ser_dat[i];
            ser_oe_n_nxt[i] = ser_fsel[i] ? SER_PERIPH_OE_N[i] : ~ser_dir[i];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            CMP_OUT <= 6'h00;
            CMP_OE_N <= 6'h3F;
            PB_OUT <= 8'h00;
            PB_OE_N <= 8'hFF;
            PC_OUT <= 8'h00;
            PC_OE_N <= 8'hFF;
            SER_OUT <= 6'h00;
            SER_OE_N <= 6'h3F;
        end else begin
            CMP_OUT <= cmp_out_nxt;
            CMP_OE_N <= {6{protect_trip}}; // [R01] [R13]
            PB_OUT <= pb_out_nxt;
            PB_OE_N <= pb_oe_n_nxt;
            PC_OUT <= pc_out_nxt;
            PC_OE_N <= pc_oe_n_nxt;
            SER_OUT <= ser_out_nxt;
            SER_OE_N <= ser_oe_n_nxt;
        end
    end

    // ------------------------------------------------------------
    // inputs delivered to peripherals
    // ------------------------------------------------------------
    // deselected inputs give each peripheral its idle level, so a pin
    // in gpio use never disturbs a timer, capture or the converter
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            TIMER_COUNT_DOWN <= 1'b0;
            TIMER_EXT_CLK <= 1'b0;
            CONVERTER_START <= 1'b0;
            EDGE_LATCH <= 4'h0;
            QUADRATURE <= 2'h0;
            BRANCH_ON_TEST_LOW <= 1'b0;
            SER_PERIPH_IN <= 6'h3F;
        end else begin
            TIMER_COUNT_DOWN <= pb_fsel[PB_TIMER_DIR] && pb_pin[PB_TIMER_DIR]; // [R04]
            TIMER_EXT_CLK <= pb_fsel[PB_TIMER_CLK] && pb_pin[PB_TIMER_CLK]; // [R05]
            CONVERTER_START <= pc_fsel[PC_CONV_START] && pc_pin[PC_CONV_START]; // [R06]
            for (int i = 0; i < 4; i++) begin
                // capture 1-2 lose their pins to the decoder in quad mode [R07]
                EDGE_LATCH[i] <= pc_fsel[PC_CAP_LSB + i] && pc_pin[PC_CAP_LSB + i] &&
                                 !(i < 2 && sys_r[SYS_QUAD_BIT]);
            end
            for (int i = 0; i < 2; i++) begin
                QUADRATURE[i] <= pc_fsel[PC_CAP_LSB + i] && pc_pin[PC_CAP_LSB + i] &&
                                 sys_r[SYS_QUAD_BIT]; // [R07]
            end
            // an unused input reads high so the branch is not taken [R09]
            BRANCH_ON_TEST_LOW <= pc_fsel[PC_BRANCH] && !pc_pin[PC_BRANCH];
            for (int i = 0; i < 6; i++) begin
                SER_PERIPH_IN[i] <= ser_fsel[i] ? ser_pin[i] : 1'b1; // [R11]
            end
        end
    end
endmodule

/* tb/shared_pin_function_mux_props.sv */
// concurrent checks on the shared pin mux top-level ports
// assumes one core clock domain and synchronous active-low reset
`timescale 1ns/10ps
module pin_mux_props (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    input wire logic POWER_DRIVE_PROTECT_N,
    input wire logic [5:0] CMP_WAVE,
    input wire logic [5:0] CMP_OUT,
    input wire logic [5:0] CMP_OE_N,
    input wire logic [7:0] PB_IN,
    input wire logic [7:0] PC_IN,
    input wire logic TIMER_COUNT_DOWN,
    input wire logic TIMER_EXT_CLK,
    input wire logic CONVERTER_START,
    input wire logic BRANCH_ON_TEST_LOW,
    input wire logic [3:0] EDGE_LATCH,
    input wire logic [1:0] QUADRATURE
);
    import pin_mux_pkg::*;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    sequence s_taken;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence s_answer;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    property p_one_wait;
        s_taken |=> s_answer;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus answer not after one wait");
    property p_low_once;
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
    endproperty
    a_low_once: assert property (p_low_once) else $error("waitrequest low too long");
    // ------------------------------------------------------------
    // compare outputs and protection
    // ------------------------------------------------------------
    // sync path needs three edges before the pins react
    property p_prot_off;
        (!POWER_DRIVE_PROTECT_N)[*4] |-> CMP_OE_N == 6'h3F;
    endproperty
    a_prot_off: assert property (p_prot_off) else $error("compare pins not high-z");
    property p_prot_on;
        POWER_DRIVE_PROTECT_N[*4] |-> CMP_OE_N == 6'h00;
    endproperty
    a_prot_on: assert property (p_prot_on) else $error("compare pins not driven");
    property p_cmp_hold;
        (!AVS_WRITE && $stable(CMP_WAVE) && POWER_DRIVE_PROTECT_N)[*5] |-> $stable(CMP_OUT);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold) else $error("compare pin moved without cause");
    // ------------------------------------------------------------
    // peripheral inputs: two sync flops plus output flop
    // ------------------------------------------------------------
    property p_down;
        TIMER_COUNT_DOWN |-> $past(PB_IN[PB_TIMER_DIR], 3);
    endproperty
    a_down: assert property (p_down) else $error("count down without high pin");
    property p_tclk;
        TIMER_EXT_CLK |-> $past(PB_IN[PB_TIMER_CLK], 3);
    endproperty
    a_tclk: assert property (p_tclk) else $error("timer clock without pin");
    property p_conv;
        CONVERTER_START |-> $past(PC_IN[PC_CONV_START], 3);
    endproperty
    a_conv: assert property (p_conv) else $error("converter start without pin");
    property p_branch;
        BRANCH_ON_TEST_LOW |-> !$past(PC_IN[PC_BRANCH], 3);
    endproperty
    a_branch: assert property (p_branch) else $error("branch taken with high pin");
    property p_quad;
        (QUADRATURE != 2'h0) |-> EDGE_LATCH[1:0] == 2'h0;
    endproperty
    a_quad: assert property (p_quad) else $error("capture and quadrature both fed");
endmodule
bind shared_pin_function_mux pin_mux_props u_props (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .POWER_DRIVE_PROTECT_N(POWER_DRIVE_PROTECT_N), .CMP_WAVE(CMP_WAVE), .CMP_OUT(CMP_OUT),
    .CMP_OE_N(CMP_OE_N), .PB_IN(PB_IN), .PC_IN(PC_IN), .TIMER_COUNT_DOWN(TIMER_COUNT_DOWN),
    .TIMER_EXT_CLK(TIMER_EXT_CLK), .CONVERTER_START(CONVERTER_START),
    .BRANCH_ON_TEST_LOW(BRANCH_ON_TEST_LOW), .EDGE_LATCH(EDGE_LATCH), .QUADRATURE(QUADRATURE));

/* tb/pin_side_model.sv */
// board side of a group of shared pins: device, outside driver, pull-up
// assumes the outside driver never fights a pin the device drives
`timescale 1ns/10ps
module pin_side_model #(
    parameter int W = 8
) (
    input wire logic [W-1:0] dev_out,
    input wire logic [W-1:0] dev_oe_n,
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] pin_lvl
);
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!dev_oe_n[i]) pin_lvl[i] = dev_out[i];
            else if (ext_en[i]) pin_lvl[i] = ext_val[i];
            else pin_lvl[i] = 1'b1; // released pins float up
        end
    end
endmodule

/* tb/shared_pin_function_mux_tb.sv */
// self-checking bench for the shared pin mux
// assumes pin_side_model on port b, port c and serial pins, protect driven directly
`timescale 1ns/10ps
module shared_pin_function_mux_tb;
    import pin_mux_pkg::*;
    logic CORE_CLK = 1'b0, RSTN = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0, PROT_N = 1'b1;
    logic [4:0] AVS_ADDRESS = 5'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
    logic AVS_WAITREQUEST, DOWN, TCLK, CONV, BRANCH;
    logic [5:0] CMP_WAVE = 6'h2B, SPO = 6'h2D, SPOE = 6'h32, SPI, CMP_OUT, CMP_OE_N;
    logic [2:0] SIMPLE_WAVE = 3'h5, TIMER_WAVE = 3'h6;
    logic [3:0] CLK_SRC = 4'h6, EDGE, BE = 4'hF;
    logic [1:0] QUAD;
    logic [7:0] PB_IN, PB_OUT, PB_OE_N, PC_IN, PC_OUT, PC_OE_N;
    logic [7:0] pb_x = 8'h0, pb_en = 8'h0, pc_x = 8'h0, pc_en = 8'h0;
    logic [5:0] SER_IN, SER_OUT, SER_OE_N, sr_x = 6'h0, sr_en = 6'h0;
    int num_errors = 0, checked = 0;
    initial forever #5 CORE_CLK = ~CORE_CLK;
    shared_pin_function_mux dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(BE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .POWER_DRIVE_PROTECT_N(PROT_N), .CMP_WAVE(CMP_WAVE), .SIMPLE_WAVE(SIMPLE_WAVE),
        .TIMER_WAVE(TIMER_WAVE), .CLK_SRC(CLK_SRC), .SER_PERIPH_OUT(SPO),
        .SER_PERIPH_OE_N(SPOE), .SER_PERIPH_IN(SPI), .TIMER_COUNT_DOWN(DOWN),
        .TIMER_EXT_CLK(TCLK), .CONVERTER_START(CONV), .EDGE_LATCH(EDGE), .QUADRATURE(QUAD),
        .BRANCH_ON_TEST_LOW(BRANCH), .CMP_OUT(CMP_OUT), .CMP_OE_N(CMP_OE_N), .PB_IN(PB_IN),
        .PB_OUT(PB_OUT), .PB_OE_N(PB_OE_N), .PC_IN(PC_IN), .PC_OUT(PC_OUT),
        .PC_OE_N(PC_OE_N), .SER_IN(SER_IN), .SER_OUT(SER_OUT), .SER_OE_N(SER_OE_N));
    pin_side_model #(.W(8)) pb_side (.dev_out(PB_OUT), .dev_oe_n(PB_OE_N), .ext_val(pb_x),
        .ext_en(pb_en), .pin_lvl(PB_IN));
    pin_side_model #(.W(8)) pc_side (.dev_out(PC_OUT), .dev_oe_n(PC_OE_N), .ext_val(pc_x),
        .ext_en(pc_en), .pin_lvl(PC_IN));
    pin_side_model #(.W(6)) sr_side (.dev_out(SER_OUT), .dev_oe_n(SER_OE_N), .ext_val(sr_x),
        .ext_en(sr_en), .pin_lvl(SER_IN));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic ticks(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask
    // one task for both directions keeps the wait loop in one place
    // no local limit: a hung slave is ended by the watchdog
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do begin
            @(posedge CORE_CLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge CORE_CLK);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    function automatic logic [5:0] act(input logic [1:0] c, input logic [5:0] w);
        case (c)
            2'h0: return 6'h00;
            2'h1: return ~w;
            2'h2: return w;
            default: return 6'h3F;
        endcase
    endfunction
    task automatic conclude;
        $display("compares %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        ticks(20000);
        num_errors++;
        conclude();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        ticks(8);
        RSTN <= 1'b1;
        ticks(4);
        rchk(ADDR_SYSTEM, 32'h00000510);
        rchk(ADDR_PORT_B, 32'hFF000000);
        bus(1'b1, 5'h14, 32'hFFFFFFFF);
        rchk(5'h14, 32'h0);
        BE <= 4'h4;
        bus(1'b1, ADDR_ACTION, 32'hFFFFFFFF);
        BE <= 4'hF;
        rchk(ADDR_ACTION, 32'h003F0000);
        $display("test reset done");
        bus(1'b1, ADDR_PORT_B, 32'h0000003F);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, ADDR_ACTION, {2'h0, {3{c[1:0]}}, 2'h0, {3{c[1:0]}}, 4'h0, {6{c[1:0]}}});
            ticks(2);
            chk(CMP_OUT, act(c[1:0], CMP_WAVE));
            chk(PB_OUT[2:0], act(c[1:0], {3'h0, SIMPLE_WAVE}) & 6'h07);
            chk(PB_OUT[5:3], act(c[1:0], {3'h0, TIMER_WAVE}) & 6'h07);
            chk({CMP_OE_N, PB_OE_N[5:0]}, 32'h0);
        end
        $display("test compare done");
        PROT_N <= 1'b0;
        ticks(5);
        chk({CMP_OE_N, PB_OE_N[5:0]}, 32'hFFF);
        rchk(ADDR_SYSTEM, 32'h00000610);
        PROT_N <= 1'b1;
        ticks(5);
        chk({CMP_OE_N, PB_OE_N[5:0]}, 32'h0);
        $display("test protect done");
        bus(1'b1, ADDR_PORT_B, 32'h00A5FF00);
        ticks(2);
        chk({PB_OUT, PB_OE_N}, 32'hA500);
        bus(1'b1, ADDR_PORT_B, 32'h000000C0);
        pb_x <= 8'hBC;
        pb_en <= 8'hFF;
        ticks(5);
        chk(PB_OE_N[7:6], 32'h3);
        rchk(ADDR_PORT_B, 32'hBC0000C0);
        chk({DOWN, TCLK}, 32'h1);
        pb_x <= 8'hC0;
        ticks(5);
        chk({DOWN, TCLK}, 32'h3);
        $display("test port b done");
        pc_x <= 8'hF1;
        pc_en <= 8'hF9;
        bus(1'b1, ADDR_PORT_C, 32'h000000FF);
        ticks(5);
        chk({CONV, BRANCH, EDGE, QUAD}, 32'hFC);
        pc_x <= 8'hF8;
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, ADDR_SYSTEM, 32'h19 | (s << 1));
            ticks(5);
            chk(PC_OUT[1], CLK_SRC[s]);
        end
        chk({CONV, BRANCH, EDGE, QUAD}, 32'h33);
        chk({PC_OUT[2], PC_OE_N[2:1]}, 32'h4);
        bus(1'b1, ADDR_SYSTEM, 32'h10);
        ticks(5);
        chk({PC_OUT[2], BRANCH}, 32'h0);
        $display("test port c done");
        sr_x <= 6'h00;
        sr_en <= 6'h02;
        bus(1'b1, ADDR_SERIAL, 32'h0000003F);
        ticks(5);
        chk({SER_OE_N, SER_OUT & 6'h0D}, 32'hC8D);
        chk(SPI & 6'h32, 32'h30);
        sr_en <= 6'h00;
        bus(1'b1, ADDR_SERIAL, 32'h00153F00);
        ticks(5);
        chk({SER_OE_N, SER_OUT, SPI}, 32'h0057F);
        $display("test serial done");
        conclude();
    end
endmodule
